// *** shared/psi_pkg.sv ***
// constants of the printer status indicator: timing, register map, codes
// assumes a 20 MHz system clock and an AXI4-Lite master with 8-bit addresses
package psi_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ      = 20_000_000;
	localparam int UNIT_MS     = 100;
	localparam int UNIT_CYCLES = CLK_HZ / 1000 * UNIT_MS;
	localparam int BLINK_MS    = 500;
	localparam int DBL_ON_MS   = 200;
	localparam int DBL_GAP_MS  = 200;
	localparam int DBL_OFF_MS  = 400;
	localparam int FAST_MS     = 100;
	localparam int ACK_MS      = 200;
	localparam int ACK_CYCLES  = CLK_HZ / 1000 * ACK_MS;

	localparam logic [3:0] BLINK_U   = 4'(BLINK_MS / UNIT_MS);
	localparam logic [3:0] PERIOD_U  = 4'(2 * BLINK_MS / UNIT_MS);
	localparam logic [3:0] DBL_ON_U  = 4'(DBL_ON_MS / UNIT_MS);
	localparam logic [3:0] DBL_GAP_U = 4'(DBL_GAP_MS / UNIT_MS);
	localparam logic [3:0] DBL_OFF_U = 4'(DBL_OFF_MS / UNIT_MS);
	localparam logic [3:0] FAST_U    = 4'(FAST_MS / UNIT_MS);
	localparam logic [9:0] DBL_SEQ   = 10'h330;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int         ADDR_W     = 8;
	localparam logic [7:0] ADDR_COND  = 8'h00;
	localparam logic [7:0] ADDR_INK   = 8'h04;
	localparam logic [7:0] ADDR_FAULT = 8'h08;
	localparam logic [7:0] ADDR_CTRL  = 8'h0c;
	localparam logic [7:0] ADDR_STAT  = 8'h10;

	localparam int COND_W  = 14;
	localparam int C_DATA  = 0;
	localparam int C_SEQ   = 1;
	localparam int C_CHG   = 2;
	localparam int C_TEAR  = 3;
	localparam int C_COVER = 4;
	localparam int C_CMODE = 5;
	localparam int C_MISM  = 6;
	localparam int C_JAM   = 7;
	localparam int C_WASTE = 8;
	localparam int C_POFF  = 9;
	localparam int C_PRINT = 10;
	localparam int C_MATTE = 11;
	localparam int C_LINK4 = 12;
	localparam int C_PAPER = 13;

	localparam int ROWS     = 8;
	localparam int INK_W    = 24;
	localparam int INK_LOW  = 0;
	localparam int INK_OUT  = 8;
	localparam int INK_CART = 16;

	localparam int FAULT_W = 6;

	localparam int K_BTN   = 0;
	localparam int K_ACK   = 1;
	localparam int K_LOADF = 2;

	localparam int ST_CODE   = 0;
	localparam int ST_PRI    = 8;
	localparam int ST_ERR    = 16;
	localparam int ST_FATAL  = 17;
	localparam int ST_POUT   = 18;
	localparam int ST_INKCOL = 19;
	localparam int ST_ACK    = 20;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// priorities and error codes
	// ----------------------------------------------------------------
	typedef logic [4:0] pri_t;
	localparam pri_t PRI_POFF   = 5'h01;
	localparam pri_t PRI_MAINT  = 5'h02;
	localparam pri_t PRI_FATAL  = 5'h04;
	localparam pri_t PRI_INKCOL = 5'h07;
	localparam pri_t PRI_JAM    = 5'h08;
	localparam pri_t PRI_CART   = 5'h09;
	localparam pri_t PRI_INKEND = 5'h0a;
	localparam pri_t PRI_POUT   = 5'h0b;
	localparam pri_t PRI_MISM   = 5'h0c;
	localparam pri_t PRI_COVER  = 5'h0d;
	localparam pri_t PRI_TEAR   = 5'h0e;
	localparam pri_t PRI_LOW    = 5'h0f;
	localparam pri_t PRI_CHG    = 5'h10;
	localparam pri_t PRI_SEQ    = 5'h11;
	localparam pri_t PRI_DATA   = 5'h13;
	localparam pri_t PRI_IDLE   = 5'h14;

	localparam logic [7:0] CODE_FATAL  = 8'h00;
	localparam logic [7:0] CODE_JAM    = 8'h04;
	localparam logic [7:0] CODE_INK    = 8'h05;
	localparam logic [7:0] CODE_POUT   = 8'h06;
	localparam logic [7:0] CODE_MISM   = 8'h0c;
	localparam logic [7:0] CODE_MAINT  = 8'h10;
	localparam logic [7:0] CODE_TEAR   = 8'h11;
	localparam logic [7:0] CODE_COVER  = 8'h2b;
	localparam logic [7:0] CODE_INKCOL = 8'h1f;
	localparam logic [7:0] CODE_NONE   = 8'hff;

	typedef enum logic [1:0] {ACK_IDLE = 2'h1, ACK_SHOW = 2'h2} ack_e;

endpackage

// *** verilog/blink_gen.sv ***
// lamp pattern generator: one 0.1 s tick and a ten-step phase
// assumes synchronous active-low reset on the system clock
`timescale 1ns/100ps
`default_nettype none
module blink_gen #(
	parameter int TICK_CYCLES = psi_pkg::UNIT_CYCLES
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	output logic      blink,
	output logic      dbl,
	output logic      fast,
	output logic      alt1,
	output logic      alt2
);
	localparam int CW = $clog2(TICK_CYCLES + 1);

	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic [3:0]    phase_r;
	logic [3:0]    phase_nxt;
	logic          tick;

	always_comb begin
		tick      = (cnt_r == CW'(TICK_CYCLES - 1));
		cnt_nxt   = tick ? '0 : cnt_r + 1'b1;
		phase_nxt = phase_r;
		if (tick) begin
			phase_nxt = (phase_r == psi_pkg::PERIOD_U - 4'h1) ? 4'h0 : phase_r + 4'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r   <= '0;
			phase_r <= 4'h0;
		end else begin
			cnt_r   <= cnt_nxt;
			phase_r <= phase_nxt;
		end
	end

	// all patterns share one phase so alternating lamps never drift apart
	always_comb begin
		blink = (phase_r < psi_pkg::BLINK_U);
		fast  = ((phase_r / psi_pkg::FAST_U) % 4'h2) == 4'h0;
		dbl   = (phase_r < psi_pkg::DBL_ON_U) ||
			((phase_r >= psi_pkg::DBL_ON_U + psi_pkg::DBL_GAP_U) &&
			(phase_r < 4'h2 * psi_pkg::DBL_ON_U + psi_pkg::DBL_GAP_U));
		alt1  = blink;
		alt2  = !blink;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [3:0] run_r;
	logic [9:0] hist_r;
	logic       warm_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_r  <= 4'h0;
			hist_r <= 10'h000;
			warm_r <= 1'b0;
		end else if (tick) begin
			run_r  <= (phase_nxt < psi_pkg::BLINK_U) != blink ? 4'h0 : run_r + 4'h1;
			hist_r <= {hist_r[8:0], dbl};
			warm_r <= warm_r | (phase_r == psi_pkg::PERIOD_U - 4'h1);
		end
	end

	a_blink_halves: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(blink) |-> $past(run_r) == psi_pkg::BLINK_U - 4'h1)
		else $error("blink half is not five ticks");
	a_fast_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(tick) |-> fast != $past(fast))
		else $error("fast blink did not toggle on a tick");
	a_dbl_shape: assert property (@(posedge aclk) disable iff (!aresetn)
		(phase_r == 4'h0 && $past(tick) && warm_r) |-> hist_r == psi_pkg::DBL_SEQ)
		else $error("double blink shape wrong");

endmodule
`default_nettype wire

// *** verilog/printer_status_indicator.sv ***
// printer status arbitration, lamp drive and host error lines
// assumes an AXI4-Lite master on aclk; firmware mirrors conditions into registers
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
`default_nettype none

module printer_status_indicator #(
	parameter int TICK_CYCLES = psi_pkg::UNIT_CYCLES,
	parameter int ACK_CYCLES  = psi_pkg::ACK_CYCLES
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             power_lamp,
	output logic             paper_lamp,
	output logic [7:0]       ink_lamp,
	output logic [7:0]       error_code,
	output logic             error_n,
	output logic             busy,
	output logic             print_stop,
	output logic             host_comm_en
);
	localparam int AW = $clog2(ACK_CYCLES + 1);

	logic [psi_pkg::COND_W-1:0]  cond_r, cond_nxt;
	logic [psi_pkg::INK_W-1:0]   ink_r, ink_nxt;
	logic [psi_pkg::FAULT_W-1:0] fault_r, fault_nxt;
	logic [7:0]                  awaddr_r, awaddr_nxt;
	logic [31:0]                 wdata_r, wdata_nxt, m, rdata_nxt;
	logic [3:0]                  wstrb_r, wstrb_nxt;
	logic                        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
	logic                        awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
	logic [1:0]                  bresp_nxt, rresp_nxt;
	logic                        btn_c, ack_c, loadf_c;
	logic                        blink, dbl, fast, alt1, alt2;
	logic [31:0]                 stat_w;

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	function automatic logic [31:0] bmask(input logic [3:0] s);
		bmask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	always_comb begin
		awaddr_nxt  = awaddr_r;
		wdata_nxt   = wdata_r;
		wstrb_nxt   = wstrb_r;
		aw_hold_nxt = aw_hold_r;
		w_hold_nxt  = w_hold_r;
		bvalid_nxt  = bvalid;
		bresp_nxt   = bresp;
		rvalid_nxt  = rvalid;
		rresp_nxt   = rresp;
		rdata_nxt   = rdata;
		cond_nxt    = cond_r;
		ink_nxt     = ink_r;
		fault_nxt   = fault_r;
		btn_c       = 1'b0;
		ack_c       = 1'b0;
		loadf_c     = 1'b0;
		m           = bmask(wstrb_r);
		if (awvalid && awready) begin
			aw_hold_nxt = 1'b1;
			awaddr_nxt  = awaddr;
		end
		if (wvalid && wready) begin
			w_hold_nxt = 1'b1;
			wdata_nxt  = wdata;
			wstrb_nxt  = wstrb;
		end
		if (bvalid && bready) begin
			bvalid_nxt = 1'b0;
		end
		if (aw_hold_r && w_hold_r && !bvalid) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = psi_pkg::RESP_OKAY;
			if (awaddr_r == psi_pkg::ADDR_COND) begin
				cond_nxt = cond_r & ~m[psi_pkg::COND_W-1:0] | wdata_r[psi_pkg::COND_W-1:0] &
					m[psi_pkg::COND_W-1:0];
			end else if (awaddr_r == psi_pkg::ADDR_INK) begin
				ink_nxt = ink_r & ~m[psi_pkg::INK_W-1:0] | wdata_r[psi_pkg::INK_W-1:0] &
					m[psi_pkg::INK_W-1:0];
			end else if (awaddr_r == psi_pkg::ADDR_FAULT) begin
				// faults only accumulate; nothing but reset clears them
				fault_nxt = fault_r | (wdata_r[psi_pkg::FAULT_W-1:0] & m[psi_pkg::FAULT_W-1:0]);
			end else if (awaddr_r == psi_pkg::ADDR_CTRL) begin
				btn_c   = wdata_r[psi_pkg::K_BTN] & m[psi_pkg::K_BTN];
				ack_c   = wdata_r[psi_pkg::K_ACK] & m[psi_pkg::K_ACK];
				loadf_c = wdata_r[psi_pkg::K_LOADF] & m[psi_pkg::K_LOADF];
			end else if (awaddr_r != psi_pkg::ADDR_STAT) begin
				bresp_nxt = psi_pkg::RESP_SLVERR;
			end
		end
		if (rvalid && rready) begin
			rvalid_nxt = 1'b0;
		end
		if (arvalid && arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = psi_pkg::RESP_OKAY;
			rdata_nxt  = 32'h0;
			if (araddr == psi_pkg::ADDR_COND) begin
				rdata_nxt[psi_pkg::COND_W-1:0] = cond_r;
			end else if (araddr == psi_pkg::ADDR_INK) begin
				rdata_nxt[psi_pkg::INK_W-1:0] = ink_r;
			end else if (araddr == psi_pkg::ADDR_FAULT) begin
				rdata_nxt[psi_pkg::FAULT_W-1:0] = fault_r;
			end else if (araddr == psi_pkg::ADDR_STAT) begin
				rdata_nxt = stat_w;
			end else if (araddr != psi_pkg::ADDR_CTRL) begin
				rresp_nxt = psi_pkg::RESP_SLVERR;
			end
		end
		awready_nxt = !aw_hold_nxt && !bvalid_nxt;
		wready_nxt  = !w_hold_nxt && !bvalid_nxt;
		arready_nxt = !rvalid_nxt;
	end

	// ----------------------------------------------------------------
	// condition state and reset acknowledge
	// ----------------------------------------------------------------
	logic        pout_r, pout_nxt, maint_r, maint_nxt, ref_r, ref_nxt, prq_r, prq_nxt;
	logic        inkcol_c, err_c, fatal_c, any_c;
	logic [AW-1:0] ack_cnt_r, ack_cnt_nxt;
	psi_pkg::ack_e ack_st_r, ack_st_nxt;
	logic [7:0]  low_w, out_w, cart_w;

	always_comb begin
		low_w    = ink_r[psi_pkg::INK_LOW +: psi_pkg::ROWS];
		out_w    = ink_r[psi_pkg::INK_OUT +: psi_pkg::ROWS];
		cart_w   = ink_r[psi_pkg::INK_CART +: psi_pkg::ROWS];
		prq_nxt  = cond_r[psi_pkg::C_PRINT];
		// the black type seen when printing starts is the reference
		ref_nxt  = (cond_r[psi_pkg::C_PRINT] && !prq_r) ? cond_r[psi_pkg::C_MATTE] : ref_r;
		inkcol_c = cond_r[psi_pkg::C_PRINT] && prq_r && (cond_r[psi_pkg::C_MATTE] != ref_r);
		// a load failure in the same cycle as the button keeps paper out set
		pout_nxt = loadf_c | (pout_r & !(btn_c & cond_r[psi_pkg::C_PAPER]));
		maint_nxt = maint_r | cond_r[psi_pkg::C_WASTE];
		fatal_c  = maint_r | (|fault_r);
		err_c    = fatal_c | inkcol_c | cond_r[psi_pkg::C_JAM] | (|cart_w) | (|out_w) | pout_r |
			cond_r[psi_pkg::C_MISM] | (cond_r[psi_pkg::C_COVER] & cond_r[psi_pkg::C_CMODE]);
		any_c    = err_c | cond_r[psi_pkg::C_POFF] | cond_r[psi_pkg::C_TEAR] | (|low_w) |
			cond_r[psi_pkg::C_CHG] | cond_r[psi_pkg::C_SEQ] | cond_r[psi_pkg::C_DATA];
		ack_st_nxt  = ack_st_r;
		ack_cnt_nxt = ack_cnt_r;
		case (ack_st_r)
			psi_pkg::ACK_IDLE: begin
				if (ack_c) begin
					ack_st_nxt  = psi_pkg::ACK_SHOW;
					ack_cnt_nxt = '0;
				end
			end
			psi_pkg::ACK_SHOW: begin
				if (ack_c) begin
					ack_cnt_nxt = '0;
				end else if (ack_cnt_r == AW'(ACK_CYCLES - 1)) begin
					ack_st_nxt = psi_pkg::ACK_IDLE;
				end else begin
					ack_cnt_nxt = ack_cnt_r + 1'b1;
				end
			end
			default: ack_st_nxt = psi_pkg::ACK_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// arbitration and lamps
	// ----------------------------------------------------------------
	psi_pkg::pri_t pri_r, pri_nxt;
	logic [7:0] code_nxt, ink_lamp_nxt;
	logic       pw_nxt, pp_nxt, show;

	always_comb begin
		show = (ack_st_r == psi_pkg::ACK_SHOW);
		// the winner decides its code; lower conditions only fill lamps it leaves open
		if (cond_r[psi_pkg::C_POFF]) begin
			{pri_nxt, code_nxt} = {psi_pkg::PRI_POFF, psi_pkg::CODE_NONE};
		end else if (maint_r) begin
			{pri_nxt, code_nxt} = {psi_pkg::PRI_MAINT, psi_pkg::CODE_MAINT};
		end else if (|fault_r) begin
			{pri_nxt, code_nxt} = {psi_pkg::PRI_FATAL, psi_pkg::CODE_FATAL};
		end else if (inkcol_c) begin
			{pri_nxt, code_nxt} = {psi_pkg::PRI_INKCOL, psi_pkg::CODE_INKCOL};
		end else if (cond_r[psi_pkg::C_JAM]) begin
			{pri_nxt, code_nxt} = {psi_pkg::PRI_JAM, psi_pkg::CODE_JAM};
		end else if (|cart_w) begin
			{pri_nxt, code_nxt} = {psi_pkg::PRI_CART, psi_pkg::CODE_INK};
		end else if (|out_w) begin
			{pri_nxt, code_nxt} = {psi_pkg::PRI_INKEND, psi_pkg::CODE_INK};
		end else if (pout_r) begin
			{pri_nxt, code_nxt} = {psi_pkg::PRI_POUT, psi_pkg::CODE_POUT};
		end else if (cond_r[psi_pkg::C_MISM]) begin
			{pri_nxt, code_nxt} = {psi_pkg::PRI_MISM, psi_pkg::CODE_MISM};
		end else if (cond_r[psi_pkg::C_COVER] && cond_r[psi_pkg::C_CMODE]) begin
			{pri_nxt, code_nxt} = {psi_pkg::PRI_COVER, psi_pkg::CODE_COVER};
		end else if (cond_r[psi_pkg::C_TEAR]) begin
			{pri_nxt, code_nxt} = {psi_pkg::PRI_TEAR, psi_pkg::CODE_TEAR};
		end else if (|low_w) begin
			{pri_nxt, code_nxt} = {psi_pkg::PRI_LOW, psi_pkg::CODE_NONE};
		end else if (cond_r[psi_pkg::C_CHG]) begin
			{pri_nxt, code_nxt} = {psi_pkg::PRI_CHG, psi_pkg::CODE_NONE};
		end else if (cond_r[psi_pkg::C_SEQ]) begin
			{pri_nxt, code_nxt} = {psi_pkg::PRI_SEQ, psi_pkg::CODE_NONE};
		end else if (cond_r[psi_pkg::C_DATA]) begin
			{pri_nxt, code_nxt} = {psi_pkg::PRI_DATA, psi_pkg::CODE_NONE};
		end else begin
			{pri_nxt, code_nxt} = {psi_pkg::PRI_IDLE, psi_pkg::CODE_NONE};
		end
		if (cond_r[psi_pkg::C_POFF]) pw_nxt = fast;
		else if (show) pw_nxt = 1'b1;
		else if (fatal_c) pw_nxt = 1'b0;
		else if (cond_r[psi_pkg::C_COVER] && cond_r[psi_pkg::C_CMODE]) pw_nxt = fast;
		else if (cond_r[psi_pkg::C_CHG] | cond_r[psi_pkg::C_SEQ] | cond_r[psi_pkg::C_DATA])
			pw_nxt = blink;
		else pw_nxt = 1'b1;
		if (cond_r[psi_pkg::C_POFF]) pp_nxt = 1'b0;
		else if (show) pp_nxt = 1'b1;
		else if (maint_r) pp_nxt = alt1;
		else if (|fault_r) pp_nxt = fast;
		else if (cond_r[psi_pkg::C_JAM]) pp_nxt = blink;
		else if (pout_r) pp_nxt = 1'b1;
		else if (cond_r[psi_pkg::C_MISM]) pp_nxt = fast;
		else if (cond_r[psi_pkg::C_COVER] && cond_r[psi_pkg::C_CMODE]) pp_nxt = dbl;
		else pp_nxt = 1'b0;
		for (int i = 0; i < psi_pkg::ROWS; i++) begin
			if (cond_r[psi_pkg::C_POFF]) ink_lamp_nxt[i] = 1'b0;
			else if (show) ink_lamp_nxt[i] = 1'b1;
			else if (maint_r) ink_lamp_nxt[i] = alt2;
			else if (|fault_r) ink_lamp_nxt[i] = fast;
			else if (cart_w[i] | out_w[i]) ink_lamp_nxt[i] = 1'b1;
			else ink_lamp_nxt[i] = low_w[i] & blink;
		end
		stat_w = 32'h0;
		stat_w[psi_pkg::ST_CODE +: 8] = error_code;
		stat_w[psi_pkg::ST_PRI +: 5]  = pri_r;
		stat_w[psi_pkg::ST_ERR]       = err_c;
		stat_w[psi_pkg::ST_FATAL]     = fatal_c;
		stat_w[psi_pkg::ST_POUT]      = pout_r;
		stat_w[psi_pkg::ST_INKCOL]    = inkcol_c;
		stat_w[psi_pkg::ST_ACK]       = show;
	end

	blink_gen #(.TICK_CYCLES(TICK_CYCLES)) u_blink (
		.aclk    (aclk),
		.aresetn (aresetn),
		.blink   (blink),
		.dbl     (dbl),
		.fast    (fast),
		.alt1    (alt1),
		.alt2    (alt2)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{awaddr_r, wdata_r, wstrb_r, aw_hold_r, w_hold_r} <= '0;
			{awready, wready, arready} <= 3'h7;
			{bvalid, rvalid, bresp, rresp, rdata} <= '0;
			{cond_r, ink_r, fault_r} <= '0;
			{pout_r, maint_r, ref_r, prq_r} <= 4'h0;
			ack_st_r   <= psi_pkg::ACK_IDLE;
			ack_cnt_r  <= '0;
			pri_r      <= psi_pkg::PRI_IDLE;
			error_code <= psi_pkg::CODE_NONE;
			{power_lamp, paper_lamp, ink_lamp} <= '0;
			{error_n, busy, print_stop, host_comm_en} <= 4'h9;
		end else begin
			{awaddr_r, wdata_r, wstrb_r} <= {awaddr_nxt, wdata_nxt, wstrb_nxt};
			{aw_hold_r, w_hold_r} <= {aw_hold_nxt, w_hold_nxt};
			{awready, wready, arready} <= {awready_nxt, wready_nxt, arready_nxt};
			{bvalid, rvalid, bresp, rresp} <= {bvalid_nxt, rvalid_nxt, bresp_nxt, rresp_nxt};
			rdata      <= rdata_nxt;
			{cond_r, ink_r, fault_r} <= {cond_nxt, ink_nxt, fault_nxt};
			{pout_r, maint_r, ref_r, prq_r} <= {pout_nxt, maint_nxt, ref_nxt, prq_nxt};
			ack_st_r   <= ack_st_nxt;
			ack_cnt_r  <= ack_cnt_nxt;
			pri_r      <= pri_nxt;
			error_code <= code_nxt;
			{power_lamp, paper_lamp, ink_lamp} <= {pw_nxt, pp_nxt, ink_lamp_nxt};
			error_n    <= !err_c;
			busy       <= err_c;
			print_stop <= err_c;
			host_comm_en <= !err_c || cond_r[psi_pkg::C_LINK4];
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_ack_req;
		ack_c && !cond_r[psi_pkg::C_POFF];
	endsequence
	sequence s_all_on;
		power_lamp && paper_lamp && (&ink_lamp);
	endsequence

	a_idle_power: assert property (!any_c && !show |=> power_lamp && pri_r == psi_pkg::PRI_IDLE)
		else $error("idle does not light power lamp");
	a_min_pri: assert property (fatal_c |=> pri_r <= psi_pkg::PRI_FATAL)
		else $error("fatal condition lost priority");
	a_ack_lamps: assert property (s_ack_req ##1 !cond_r[psi_pkg::C_POFF] |=> s_all_on)
		else $error("reset acknowledge did not light all lamps");
	a_ack_len: assert property (show |-> ack_cnt_r < AW'(ACK_CYCLES))
		else $error("acknowledge ran too long");
	a_cart_code: assert property ((|cart_w) && pri_nxt == psi_pkg::PRI_CART
		|=> error_code == psi_pkg::CODE_INK && (ink_lamp & $past(cart_w)) == $past(cart_w))
		else $error("missing cartridge not shown");
	a_err_lines: assert property ($rose(busy) |-> !error_n && print_stop)
		else $error("error lines disagree");
	a_comm_link: assert property (err_c && cond_r[psi_pkg::C_LINK4] |=> host_comm_en)
		else $error("packet link blocked during error");
	a_jam_resume: assert property ($fell(cond_r[psi_pkg::C_JAM]) && !err_c |=> error_n && !busy)
		else $error("jam did not clear");
	a_cover_mode: assert property (cond_r[psi_pkg::C_COVER] && !cond_r[psi_pkg::C_CMODE] && !err_c
		|=> !busy)
		else $error("cover error outside feed mode");
	a_pout_hold: assert property (pout_r && !(btn_c && cond_r[psi_pkg::C_PAPER]) |=> pout_r)
		else $error("paper out cleared without button");
	a_maint_alt: assert property (maint_r && !cond_r[psi_pkg::C_POFF] && !show
		|=> paper_lamp != ink_lamp[0] && !power_lamp)
		else $error("maintenance lamps not in antiphase");
	a_fatal_sticky: assert property (fatal_c |=> fatal_c)
		else $error("fatal error cleared without reset");
	a_low_prints: assert property ((|low_w) && !err_c |=> !print_stop)
		else $error("low ink stopped printing");

endmodule
`default_nettype wire

// *** tb/host_port_model.sv ***
// host side of the parallel printer port: holds data back while refused
// assumes the error and busy lines are sampled on aclk
`timescale 1ns/100ps
`default_nettype none
module host_port_model (
	input  wire logic aclk,
	input  wire logic error_n,
	input  wire logic busy,
	output logic      refused
);
	// data is held back only while both lines say error
	always_ff @(posedge aclk) refused <= ~error_n & busy;
endmodule
`default_nettype wire

// *** tb/printer_status_indicator_test.sv ***
// bench for the status indicator: register traffic, status and lamp checks
// assumes short tick and acknowledge counts so patterns fit a short run
`timescale 1ns/100ps
`default_nettype none
module printer_status_indicator_test;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, ink_lamp, error_code;
	logic [31:0] wdata = 32'h0, rdata, rd_v;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp, rsp;
	logic awready, wready, bvalid, arready, rvalid, power_lamp, paper_lamp;
	logic error_n, busy, print_stop, host_comm_en, refused, e;
	int errors = 0, checked = 0, n, i;
	localparam logic [31:0] TC [11] = '{0, 1, 2, 4, 0, 'h10, 'h30, 'h41, 'hc0, 0, 0};
	localparam logic [31:0] TI [11] = '{0, 0, 0, 0, 1, 0, 0, 0, 0, 'h080000, 'h8000};
	localparam logic [31:0] TS [11] = '{'h14ff, 'h13ff, 'h11ff, 'h10ff, 'h0fff, 'h14ff,
		'h10d2b, 'h10c0c, 'h10804, 'h10905, 'h10a05};
	always #25 aclk = ~aclk;
	printer_status_indicator #(.TICK_CYCLES(4), .ACK_CYCLES(8)) i_printer_status_indicator (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .power_lamp(power_lamp),
		.paper_lamp(paper_lamp), .ink_lamp(ink_lamp), .error_code(error_code), .error_n(error_n),
		.busy(busy), .print_stop(print_stop), .host_comm_en(host_comm_en));
	host_port_model i_host_port_model (.aclk(aclk), .error_n(error_n), .busy(busy),
		.refused(refused));
	task automatic conclude();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
		checked++;
		if (g !== x) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, x, g);
		end
	endtask
	// both channels are offered together and each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
		for (n = 0; n < 50 && bvalid !== 1'b1; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end
		rsp = bresp; bready <= 0;
		if (n == 50) begin errors++; conclude(); end
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a);
		araddr <= a; arvalid <= 1; rready <= 1;
		for (n = 0; n < 50 && rvalid !== 1'b1; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
		end
		rd_v = rdata; rsp = rresp; rready <= 0;
		if (n == 50) begin errors++; conclude(); end
		@(posedge aclk);
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		for (i = 0; i < 11; i++) begin
			wr(8'h00, TC[i]);
			wr(8'h04, TI[i]);
			rd(8'h10);
			e = TS[i][16];
			cmp("status", TS[i], rd_v);
			cmp("lines", {~e, e, e}, {error_n, busy, print_stop});
			cmp("code", TS[i][7:0], error_code);
		end
		cmp("ink lamps", 8'h80, ink_lamp);
		$display("priority test done");
		wr(8'h00, 0);
		wr(8'h04, 0);
		wr(8'h20, 1);
		cmp("bresp", 2'h2, rsp);
		rd(8'h20);
		cmp("rresp", 2'h2, rsp);
		cmp("rdata", 32'h0, rd_v);
		wr(8'h0c, 2);
		cmp("ack lamps", 10'h3ff, {power_lamp, paper_lamp, ink_lamp});
		repeat (12) @(posedge aclk);
		cmp("idle lamps", 10'h200, {power_lamp, paper_lamp, ink_lamp});
		$display("ack test done");
		wr(8'h0c, 4);
		cmp("paper out", {8'h06, 1'b1, 1'b0}, {error_code, paper_lamp, error_n});
		wr(8'h0c, 1);
		cmp("paper kept", 8'h06, error_code);
		wr(8'h00, 'h2000);
		wr(8'h0c, 1);
		cmp("paper back", {8'hff, 1'b1}, {error_code, error_n});
		wr(8'h00, 'h400);
		wr(8'h00, 'hc00);
		cmp("ink color", {8'h1f, 1'b1}, {error_code, busy});
		wr(8'h00, 'h400);
		cmp("ink color back", {8'hff, 1'b0}, {error_code, busy});
		wr(8'h00, 0);
		$display("general error test done");
		wr(8'h08, 1);
		wr(8'h00, 'h1000);
		rd(8'h10);
		cmp("fatal", 32'h30400, rd_v);
		cmp("host", 3'h6, {refused, host_comm_en, power_lamp});
		$display("fatal test done");
		// held long enough that no sampled pair straddles the release
		aresetn <= 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(8'h10);
		cmp("power cycle", 32'h14ff, rd_v);
		wr(8'h00, 'h100);
		wr(8'h00, 0);
		rd(8'h10);
		cmp("maint", 32'h30210, rd_v);
		e = ink_lamp[0];
		cmp("maint lamps", {1'b0, ~e, {8{e}}}, {power_lamp, paper_lamp, ink_lamp});
		$display("maintenance test done");
		conclude();
	end
endmodule
`default_nettype wire
